// *** hw/far_pkg.sv ***
// Package with settings, encodings and timing constants for the restart controller.
package far_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  // Catch-spin mode encodings.
  localparam logic [2:0] CATCH_MODE_OFF = 3'h0;
  localparam logic [2:0] CATCH_MODE_BOTH = 3'h1;
  localparam logic [2:0] CATCH_MODE_SETDIR = 3'h4;
  localparam logic [2:0] CATCH_MODE_RESET = 3'h0;
  // Enable source default: 1 means permanently enabled.
  localparam logic [1:0] CATCH_SRC_ZERO = 2'h0;
  localparam logic [1:0] CATCH_SRC_ONE = 2'h1;
  localparam logic [1:0] CATCH_SRC_DIN = 2'h2;
  localparam logic [1:0] CATCH_SRC_RESET = 2'h1;
  localparam logic [7:0] SEARCH_CURRENT_RESET = 8'h64;
  localparam logic [7:0] SWEEP_FACTOR_RESET = 8'h64;
  // Restart mode encodings.
  localparam logic [4:0] AR_OFF = 5'h00;
  localparam logic [4:0] AR_ACK_ONLY = 5'h01;
  localparam logic [4:0] AR_PF = 5'h04;
  localparam logic [4:0] AR_FAULT = 5'h06;
  localparam logic [4:0] AR_PF_MAN = 5'h0E;
  localparam logic [4:0] AR_FAULT_MAN = 5'h10;
  localparam logic [4:0] AR_ACK_ON = 5'h1A;
  localparam logic [4:0] AR_MODE_RESET = 5'h00;
  localparam logic [3:0] ATTEMPT_LIMIT_RESET = 4'h3;
  localparam logic [7:0] SUPERVISION_S_RESET = 8'h3C;
  // Success settle time after magnetising, in milliseconds.
  localparam int unsigned SETTLE_MS = 1000;
  localparam int unsigned SETTLE_CYCLES = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SECOND_CYCLES = CLK_HZ;
  // Sweep step base period per 100 % of sweep factor, in microseconds.
  localparam int unsigned SWEEP_STEP_US = 10;
  localparam int unsigned SWEEP_STEP_CYCLES = SWEEP_STEP_US * (CLK_HZ / 1000000);
  localparam logic [15:0] FREQ_MAX = 16'hFFFF;
  typedef enum logic [2:0] {
    FAR_IDLE = 3'b000,
    FAR_SEARCH = 3'b001,
    FAR_MAGNET = 3'b011,
    FAR_SETTLE = 3'b010,
    FAR_RUN = 3'b110,
    FAR_FAULTED = 3'b111
  } far_state_t;
endpackage

// *** hw/far_sweep_if.sv ***
// Interface carrying the search sweep control between controller and sweep generator.
`timescale 1ns/10ps
interface far_sweep_if;
  logic start;
  logic reverse_first;
  logic both_dirs;
  logic [7:0] factor;
  logic [15:0] freq;
  logic dir;
  logic active;
  modport ctrl (output start, output reverse_first, output both_dirs, output factor,
                input freq, input dir, input active);
  modport gen (input start, input reverse_first, input both_dirs, input factor,
               output freq, output dir, output active);
endinterface

// *** hw/far_sweep.sv ***
// Search frequency sweep generator for catching a spinning motor.
`timescale 1ns/10ps
module far_sweep
  import far_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic stop,
  far_sweep_if.gen sw
);
  logic [23:0] step_cnt;
  logic second_pass;
  // Step period grows with the factor, so a larger factor sweeps slower.
  // The counter runs from zero up to this value, so it is one below the step length in cycles.
  function automatic logic [23:0] step_period(input logic [7:0] f);
    logic [31:0] p;
    p = (SWEEP_STEP_CYCLES * 32'(f)) / 32'h64;
    step_period = (p == 32'h0) ? 24'h000000 : 24'(p - 32'h1);
  endfunction

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw.freq <= 16'h0000;
      sw.dir <= 1'b0;
      sw.active <= 1'b0;
      step_cnt <= 24'h000000;
      second_pass <= 1'b0;
    end else if (clk_en) begin
      // Start wins over stop: the controller raises it while it is still outside the search state.
      if (sw.start) begin
        sw.freq <= FREQ_MAX;
        sw.dir <= sw.reverse_first;
        sw.active <= 1'b1;
        step_cnt <= 24'h000000;
        second_pass <= 1'b0;
      end else if (stop) begin
        sw.active <= 1'b0;
      end else if (sw.active) begin
        if (step_cnt >= step_period(sw.factor)) begin
          step_cnt <= 24'h000000;
          if (sw.freq != 16'h0000) begin
            sw.freq <= sw.freq - 16'h0001;
          end else if (sw.both_dirs && !second_pass) begin
            // Sweep again in the opposite direction.
            second_pass <= 1'b1;
            sw.dir <= ~sw.dir;
            sw.freq <= FREQ_MAX;
          end else begin
            sw.active <= 1'b0;
          end
        end else begin
          step_cnt <= step_cnt + 24'h000001;
        end
      end
    end
  end
endmodule

// *** hw/far_ctrl.sv ***
// Flying-restart and automatic-restart sequencer for a motor converter.
`timescale 1ns/10ps
// Contract
// - With catch-spin enabled, a switch-on first matches output frequency to rotor speed, then ramps to setpoint.
// - Catch-spin mode resets to 0 (off); 1 searches both directions starting in setpoint direction; 4 only setpoint direction.
// - Catch-spin enable comes from a selectable source whose default 1 means always enabled.
// - During search the search current is a percentage of magnetising current, default 100 percent.
// - A sweep factor, default 100 percent, slows the sweep as it grows.
// - DC-link undervoltage or a supply loss long enough to switch off counts as a power failure.
// - Modes 1 and 26 always acknowledge faults, 4 and 6 only with switch-on asserted, 14 and 16 never.
// - Mode 1 never switches on; other active modes switch on only while switch-on is asserted.
// - An attempt succeeds only if no fault occurs one second after magnetising done.
// - Restart modes are 0, 1, 4, 6, 14, 16 and 26 with the listed meanings.
// - Restart mode resets to 0.
// - Any restart mode above 1 restarts automatically after a power failure.
// - With attempt limit n, at most n+1 attempts are made before restart-failed is raised.
// - A supervision timer, default 60 s, runs from fault to success, raises restart-failed on expiry, 0 disables.
module far_ctrl
  import far_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = SETTLE_CYCLES,
  parameter int unsigned SECOND_CNT = SECOND_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic switch_on_command,
  input wire logic catch_spin_din,
  input wire logic [2:0] catch_spin_mode,
  input wire logic [1:0] catch_spin_enable_source,
  input wire logic [7:0] catch_spin_search_current,
  input wire logic [7:0] catch_spin_sweep_factor,
  input wire logic [4:0] auto_restart_mode,
  input wire logic [3:0] restart_attempt_limit,
  input wire logic [7:0] restart_supervision_time,
  input wire logic [15:0] motor_magnetising_current,
  input wire logic setpoint_reverse,
  input wire logic speed_matched,
  input wire logic magnetising_done_flag,
  input wire logic overcurrent_fault,
  input wire logic dc_link_undervoltage_fault,
  input wire logic power_up,
  input wire logic manual_ack,
  output logic motor_enable,
  output logic ramp_enable,
  output logic search_active,
  output logic [15:0] search_freq,
  output logic search_dir,
  output logic [15:0] search_current,
  output logic fault_ack,
  output logic restart_failed_fault,
  output logic attempt_ok,
  output far_state_t state_out
);
  far_sweep_if sw ();
  far_state_t state;
  far_state_t next_state;
  logic [2:0] sync_on;
  logic [1:0] sync_din;
  logic [1:0] sync_ov;
  logic [1:0] sync_uv;
  logic [1:0] sync_mag;
  logic [1:0] sync_match;
  logic [1:0] sync_ack;
  logic [1:0] sync_pu;
  logic on_s, din_s, ov_s, uv_s, mag_s, match_s, mack_s, pu_s;
  logic fault_pending;
  logic power_fail;
  logic [4:0] attempts;
  logic [31:0] settle_cnt;
  logic [31:0] sec_cnt;
  logic [7:0] sup_secs;
  logic sup_run;
  logic catch_en;
  logic ack_now;
  logic auto_start;
  logic fault_now;
  logic sweep_start;

  // Two-flop synchronisers feed logic from their second stage; switch-on keeps a third stage for its edge.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_on <= 3'h0;
      sync_din <= 2'h0;
      sync_ov <= 2'h0;
      sync_uv <= 2'h0;
      sync_mag <= 2'h0;
      sync_match <= 2'h0;
      sync_ack <= 2'h0;
      sync_pu <= 2'h0;
    end else if (clk_en) begin
      sync_on <= {sync_on[1:0], switch_on_command};
      sync_din <= {sync_din[0], catch_spin_din};
      sync_ov <= {sync_ov[0], overcurrent_fault};
      sync_uv <= {sync_uv[0], dc_link_undervoltage_fault};
      sync_mag <= {sync_mag[0], magnetising_done_flag};
      sync_match <= {sync_match[0], speed_matched};
      sync_ack <= {sync_ack[0], manual_ack};
      sync_pu <= {sync_pu[0], power_up};
    end
  end
  assign on_s = sync_on[1];
  assign din_s = sync_din[1];
  assign ov_s = sync_ov[1];
  assign uv_s = sync_uv[1];
  assign mag_s = sync_mag[1];
  assign match_s = sync_match[1];
  assign mack_s = sync_ack[1];
  assign pu_s = sync_pu[1];

  always_comb begin
    case (catch_spin_enable_source)
      CATCH_SRC_ZERO: catch_en = 1'b0;
      CATCH_SRC_ONE: catch_en = 1'b1;
      CATCH_SRC_DIN: catch_en = din_s;
      default: catch_en = 1'b1;
    endcase
    catch_en = catch_en && (catch_spin_mode == CATCH_MODE_BOTH || catch_spin_mode == CATCH_MODE_SETDIR);
  end

  assign fault_now = ov_s | uv_s;

  always_comb begin
    case (auto_restart_mode)
      AR_ACK_ONLY, AR_ACK_ON: ack_now = 1'b1;
      AR_PF, AR_FAULT: ack_now = on_s;
      default: ack_now = 1'b0;
    endcase
    // Modes 14 and 16 still need the operator's acknowledge.
    if (auto_restart_mode == AR_PF_MAN || auto_restart_mode == AR_FAULT_MAN) begin
      ack_now = mack_s;
    end
  end

  // switch-on gating; mode set; mode 0 starts nothing; power-fail restart above 1.
  always_comb begin
    case (auto_restart_mode)
      AR_FAULT, AR_FAULT_MAN, AR_ACK_ON: auto_start = on_s;
      AR_PF, AR_PF_MAN: auto_start = on_s && power_fail;
      default: auto_start = 1'b0;
    endcase
    if (auto_restart_mode > AR_ACK_ONLY && power_fail && on_s && auto_restart_mode != AR_OFF) begin
      auto_start = 1'b1;
    end
  end

  // search precedes ramp; automatic starts also search.
  always_comb begin
    next_state = state;
    sweep_start = 1'b0;
    case (state)
      FAR_IDLE: begin
        if (on_s && !sync_on[2] && !fault_pending) begin // Only a fresh edge starts; a held command never does.
          next_state = catch_en ? FAR_SEARCH : FAR_MAGNET;
          sweep_start = catch_en;
        end
      end
      FAR_SEARCH: begin
        if (fault_now) next_state = FAR_FAULTED;
        else if (match_s) next_state = FAR_MAGNET;
        else if (!on_s) next_state = FAR_IDLE;
      end
      FAR_MAGNET: begin
        if (fault_now) next_state = FAR_FAULTED;
        else if (mag_s) next_state = FAR_SETTLE;
        else if (!on_s) next_state = FAR_IDLE;
      end
      FAR_SETTLE: begin
        if (fault_now) next_state = FAR_FAULTED;
        else if (settle_cnt >= SETTLE_CNT - 1) next_state = FAR_RUN;
        else if (!on_s) next_state = FAR_IDLE;
      end
      FAR_RUN: begin
        if (fault_now) next_state = FAR_FAULTED;
        else if (!on_s) next_state = FAR_IDLE;
      end
      FAR_FAULTED: begin
        if (ack_now && !restart_failed_fault && !fault_now) begin
          if (auto_start) begin
            next_state = catch_en ? FAR_SEARCH : FAR_MAGNET;
            sweep_start = catch_en;
          end else begin
            next_state = FAR_IDLE;
          end
        end
      end
      default: next_state = FAR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) state <= FAR_IDLE;
    else if (clk_en) state <= next_state;
  end

  // one second of fault-free running after magnetising.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) settle_cnt <= 32'h00000000;
    else if (clk_en) settle_cnt <= (state == FAR_SETTLE) ? settle_cnt + 32'h00000001 : 32'h00000000;
  end

  // undervoltage or power-up after supply loss marks a power failure.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) power_fail <= 1'b0;
    else if (clk_en) begin
      if (uv_s || pu_s) power_fail <= 1'b1;
      else if (next_state == FAR_RUN) power_fail <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      attempts <= 5'h00;
      sup_run <= 1'b0;
      sup_secs <= 8'h00;
      sec_cnt <= 32'h00000000;
      restart_failed_fault <= 1'b0;
      fault_pending <= 1'b0;
    end else if (clk_en) begin
      // Clearing restart-failed needs switch-off plus acknowledge; a new failure below overrides it.
      if (restart_failed_fault && !on_s && mack_s && !fault_now) begin
        restart_failed_fault <= 1'b0;
        attempts <= 5'h00;
        sup_run <= 1'b0;
      end
      if (state != FAR_FAULTED && next_state == FAR_FAULTED) begin
        fault_pending <= 1'b1;
        if (!sup_run) begin
          sup_run <= 1'b1;
          sup_secs <= 8'h00;
          sec_cnt <= 32'h00000000;
        end
        if (attempts >= {1'b0, restart_attempt_limit}) restart_failed_fault <= 1'b1;
        else attempts <= attempts + 5'h01;
      end else if (state == FAR_SETTLE && next_state == FAR_RUN) begin
        sup_run <= 1'b0;
        attempts <= 5'h00;
      end else if (sup_run && restart_supervision_time != 8'h00) begin
        if (sec_cnt >= SECOND_CNT - 1) begin
          sec_cnt <= 32'h00000000;
          sup_secs <= sup_secs + 8'h01;
          if (sup_secs + 8'h01 >= restart_supervision_time) restart_failed_fault <= 1'b1;
        end else begin
          sec_cnt <= sec_cnt + 32'h00000001;
        end
      end
      if (state == FAR_FAULTED && next_state != FAR_FAULTED) fault_pending <= 1'b0;
    end
  end

  // direction choice; factor passed to sweep.
  assign sw.start = sweep_start;
  assign sw.reverse_first = setpoint_reverse;
  assign sw.both_dirs = (catch_spin_mode == CATCH_MODE_BOTH);
  assign sw.factor = catch_spin_sweep_factor;

  far_sweep u_sweep (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .stop(state != FAR_SEARCH),
    .sw(sw.gen)
  );

  // Registered outputs; the search current is percentage times magnetising current.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      motor_enable <= 1'b0;
      ramp_enable <= 1'b0;
      search_active <= 1'b0;
      search_freq <= 16'h0000;
      search_dir <= 1'b0;
      search_current <= 16'h0000;
      fault_ack <= 1'b0;
      attempt_ok <= 1'b0;
      state_out <= FAR_IDLE;
    end else if (clk_en) begin
      motor_enable <= (state == FAR_SEARCH) || (state == FAR_MAGNET) || (state == FAR_SETTLE) || (state == FAR_RUN);
      ramp_enable <= (state == FAR_MAGNET) || (state == FAR_SETTLE) || (state == FAR_RUN);
      search_active <= (state == FAR_SEARCH);
      search_freq <= sw.freq;
      search_dir <= sw.dir;
      search_current <= (state == FAR_SEARCH)
        ? 16'((32'(motor_magnetising_current) * 32'(catch_spin_search_current)) / 100) : 16'h0000;
      fault_ack <= (state == FAR_FAULTED) && (next_state != FAR_FAULTED);
      attempt_ok <= (state == FAR_SETTLE) && (next_state == FAR_RUN);
      state_out <= state;
    end
  end
endmodule

// *** sim/far_ctrl_properties.sv ***
// Port-level assertions for the restart controller.
`timescale 1ns/10ps
module far_ctrl_properties
  import far_pkg::*;
#(
  parameter int unsigned SETTLE_CNT = 50
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic switch_on_command,
  input wire logic magnetising_done_flag,
  input wire logic overcurrent_fault,
  input wire logic dc_link_undervoltage_fault,
  input wire logic motor_enable,
  input wire logic ramp_enable,
  input wire logic search_active,
  input wire logic [15:0] search_current,
  input wire logic fault_ack,
  input wire logic restart_failed_fault,
  input wire logic attempt_ok
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  int unsigned mag_cnt;
  // Cycles since the magnetised flag rose; it saturates so a long run never wraps.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mag_cnt <= 0;
    end else if (!magnetising_done_flag) begin
      mag_cnt <= 0;
    end else if (mag_cnt < 32'hFFFF) begin
      mag_cnt <= mag_cnt + 1;
    end
  end
  sequence s_on_held;
    switch_on_command [*4];
  endsequence
  sequence s_fault_hit;
    (overcurrent_fault || dc_link_undervoltage_fault) && motor_enable;
  endsequence
  a_reset_quiet: assert property ($rose(reset_n) |-> !motor_enable && !attempt_ok && !restart_failed_fault)
    else $error("outputs active right after reset");
  a_no_ramp_search: assert property (search_active |-> !ramp_enable)
    else $error("ramp enabled during search");
  a_current_idle: assert property (!search_active |-> search_current == 16'h0000)
    else $error("search current outside search");
  a_settle_time: assert property (attempt_ok |-> mag_cnt >= SETTLE_CNT && mag_cnt <= SETTLE_CNT + 10)
    else $error("attempt success at wrong time");
  a_switch_gate: assert property ($rose(motor_enable) |-> $past(switch_on_command, 3))
    else $error("motor started without switch-on");
  a_ok_pulse: assert property (attempt_ok |=> !attempt_ok)
    else $error("attempt success longer than a cycle");
  a_ack_pulse: assert property (fault_ack |=> !fault_ack)
    else $error("fault ack longer than a cycle");
  a_failed_sticky: assert property (s_on_held ##0 restart_failed_fault |=> restart_failed_fault)
    else $error("restart failure cleared while on");
  a_fault_stops: assert property (s_fault_hit |-> ##[1:8] !motor_enable)
    else $error("motor not stopped on fault");
endmodule
bind far_ctrl far_ctrl_properties #(.SETTLE_CNT(SETTLE_CNT)) far_ctrl_properties_inst (.ref_clk, .reset_n,
  .switch_on_command, .magnetising_done_flag, .overcurrent_fault, .dc_link_undervoltage_fault, .motor_enable,
  .ramp_enable, .search_active, .search_current, .fault_ack, .restart_failed_fault, .attempt_ok);

// *** sim/far_motor_model.sv ***
// Behavioural spinning motor that reports speed match and magnetisation.
`timescale 1ns/10ps
module far_motor_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic search_active,
  input wire logic ramp_enable,
  input wire logic stall,
  output logic speed_matched,
  output logic magnetising_done_flag
);
  int unsigned s_cnt, m_cnt;
  // rotor found mid-search
  // The match needs some sweeping first; a stalled rotor is never found.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_cnt <= 0;
      speed_matched <= 1'b0;
    end else begin
      s_cnt <= search_active ? s_cnt + 1 : 0;
      speed_matched <= search_active && !stall && s_cnt >= 12;
    end
  end
  // flux build-up flag
  // Flux builds only while the ramp is enabled, so the flag drops at the first clock edge after it is removed.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      m_cnt <= 0;
      magnetising_done_flag <= 1'b0;
    end else begin
      m_cnt <= ramp_enable ? m_cnt + 1 : 0;
      magnetising_done_flag <= ramp_enable && m_cnt >= 8;
    end
  end
endmodule

// *** sim/far_ctrl_tb.sv ***
// Self-checking bench for the restart controller against a motor model.
`timescale 1ns/10ps
module far_ctrl_tb;
  import far_pkg::*;
  logic ref_clk, reset_n, switch_on_command, catch_spin_din, overcurrent_fault, dc_link_undervoltage_fault;
  logic manual_ack, stall, speed_matched, magnetising_done_flag, motor_enable, ramp_enable, search_active;
  logic clk_en, setpoint_reverse, power_up;
  logic search_dir, fault_ack, restart_failed_fault, attempt_ok, rf_q, seen_search;
  logic [2:0] catch_spin_mode, ev;
  logic [1:0] catch_spin_enable_source;
  logic [7:0] catch_spin_search_current, catch_spin_sweep_factor, restart_supervision_time;
  logic [4:0] auto_restart_mode;
  logic [3:0] restart_attempt_limit;
  logic [15:0] motor_magnetising_current, search_freq, search_current, f0;
  far_state_t state_out;
  logic [2:0] exp_q[$];
  logic [4:0] modes [7] = '{AR_OFF, AR_ACK_ONLY, AR_PF, AR_PF_MAN, AR_FAULT, AR_FAULT_MAN, AR_ACK_ON};
  int error_cnt = 0, tests_run = 0, cycles = 0;
  far_ctrl #(.SETTLE_CNT(50), .SECOND_CNT(20)) far_ctrl_inst (.ref_clk, .reset_n, .clk_en,
    .switch_on_command, .catch_spin_din, .catch_spin_mode, .catch_spin_enable_source, .catch_spin_search_current,
    .catch_spin_sweep_factor, .auto_restart_mode, .restart_attempt_limit, .restart_supervision_time,
    .motor_magnetising_current, .setpoint_reverse, .speed_matched, .magnetising_done_flag,
    .overcurrent_fault, .dc_link_undervoltage_fault, .power_up, .manual_ack, .motor_enable, .ramp_enable,
    .search_active, .search_freq, .search_dir, .search_current, .fault_ack, .restart_failed_fault, .attempt_ok,
    .state_out);
  far_motor_model far_motor_model_inst (.ref_clk, .reset_n, .search_active, .ramp_enable, .stall,
    .speed_matched, .magnetising_done_flag);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Each result pulse is matched against the oldest noted expectation; a pulse with no note is a fault.
  always @(negedge ref_clk) begin
    ev = {restart_failed_fault & ~rf_q, fault_ack, attempt_ok};
    rf_q = restart_failed_fault;
    if (search_active === 1'b1) seen_search = 1'b1;
    if (ev !== 3'h0) check(16'(ev), 16'(exp_q.size() ? exp_q.pop_front() : 3'h0));
  end
  // A hang is cut short well above the few thousand cycles the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wait_q(input int n);
    for (int i = 0; i < n && exp_q.size() != 0; i++) @(negedge ref_clk);
    check(16'(exp_q.size()), 16'h0);
  endtask
  task automatic do_reset();
    switch_on_command = 1'b0;
    reset_n = 1'b0;
    repeat (10) @(negedge ref_clk);
    reset_n = 1'b1;
  endtask
  task automatic go_on(input logic [2:0] e);
    exp_q.push_back(e);
    switch_on_command = 1'b1;
  endtask
  task automatic step(input logic [2:0] e, input logic uv);
    exp_q.push_back(e);
    if (uv) dc_link_undervoltage_fault = 1'b1;
    else overcurrent_fault = 1'b1;
    @(negedge ref_clk);
    dc_link_undervoltage_fault = 1'b0;
    overcurrent_fault = 1'b0;
  endtask
  task automatic man_ack();
    manual_ack = 1'b1;
    repeat (2) @(negedge ref_clk);
    manual_ack = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask
  task automatic off(input int id);
    switch_on_command = 1'b0;
    repeat (8) @(negedge ref_clk);
    $display("test %0d done", id);
  endtask
  initial begin
    int i, k, n, c;
    {catch_spin_din, overcurrent_fault, dc_link_undervoltage_fault, manual_ack, stall, rf_q} = 6'h00;
    {setpoint_reverse, power_up} = 2'h0;
    clk_en = 1'b1;
    catch_spin_mode = CATCH_MODE_BOTH;
    catch_spin_enable_source = CATCH_SRC_ONE;
    catch_spin_sweep_factor = SWEEP_FACTOR_RESET;
    restart_supervision_time = SUPERVISION_S_RESET;
    auto_restart_mode = AR_MODE_RESET;
    restart_attempt_limit = ATTEMPT_LIMIT_RESET;
    void'($urandom(32'hFF9DC5F6));
    motor_magnetising_current = 16'($urandom) & 16'h7FFF;
    catch_spin_search_current = 8'($urandom_range(200, 1));
    do_reset();
    go_on(3'h1);
    for (i = 0; i < 20 && search_active !== 1'b1; i++) @(negedge ref_clk);
    @(negedge ref_clk);
    check(search_current, 16'((32'(motor_magnetising_current) * catch_spin_search_current) / 100));
    wait_q(400);
    // Clock enable low freezes the running state although switch-on has gone.
    clk_en = 1'b0;
    switch_on_command = 1'b0;
    repeat (6) @(negedge ref_clk);
    check(16'(motor_enable), 16'h1);
    clk_en = 1'b1;
    off(1);
    // search gated by mode and source
    for (k = 0; k < 3; k++) begin
      catch_spin_mode = (k == 2) ? CATCH_MODE_OFF : CATCH_MODE_SETDIR;
      catch_spin_enable_source = (k == 0) ? CATCH_SRC_ZERO : CATCH_SRC_DIN;
      catch_spin_din = 1'b1;
      seen_search = 1'b0;
      go_on(3'h1);
      wait_q(400);
      check(16'(seen_search), 16'(k == 1));
      off(2);
    end
    catch_spin_mode = CATCH_MODE_BOTH;
    // acknowledge for every mode above 0, restart for every mode above 1
    for (k = 0; k < 7; k++) begin
      do_reset();
      auto_restart_mode = modes[k];
      go_on(3'h1);
      wait_q(400);
      // Mode 4 learns of its power failure from the supply-loss input instead of undervoltage.
      power_up = (k == 2);
      step((k != 0) ? 3'h2 : 3'h0, k < 4 && k != 2);
      power_up = 1'b0;
      if (k == 0) void'(exp_q.pop_back());
      // The restart's success pulse follows the acknowledge pulse.
      if (k > 1) exp_q.push_back(3'h1);
      if (k == 3 || k == 5) begin
        repeat (10) @(negedge ref_clk);
        check(16'(exp_q.size()), 16'h2);
        man_ack();
      end
      wait_q(400);
      repeat (10) @(negedge ref_clk);
      check(16'(motor_enable), 16'(k > 1));
      off(3);
    end
    do_reset();
    auto_restart_mode = AR_FAULT;
    n = $urandom_range(2, 0);
    restart_attempt_limit = 4'(n);
    go_on(3'h1);
    wait_q(400);
    for (k = 0; k <= n; k++) begin
      step((k < n) ? 3'h2 : 3'h4, 1'b0);
      wait_q(100);
      repeat (8) @(negedge ref_clk);
    end
    check(16'(restart_failed_fault), 16'h1);
    off(4);
    man_ack();
    check(16'(restart_failed_fault), 16'h0);
    // sweep step stretched by the factor
    do_reset();
    catch_spin_sweep_factor = 8'hC8;
    stall = 1'b1;
    setpoint_reverse = 1'($urandom);
    switch_on_command = 1'b1;
    for (i = 0; i < 50 && search_active !== 1'b1; i++) @(negedge ref_clk);
    f0 = search_freq;
    for (i = 0; i < 1000 && search_freq === f0; i++) @(negedge ref_clk);
    f0 = search_freq;
    for (c = 0; c < 1000 && search_freq === f0; c++) @(negedge ref_clk);
    check(16'(c), 16'(SWEEP_STEP_CYCLES * 200 / 100));
    check(16'(search_dir), 16'(setpoint_reverse));
    // supervision expiry while the rotor is never found
    restart_supervision_time = 8'h01;
    // With a limit of zero the fault itself fails the restart; otherwise the timer does after one retry.
    step((n != 0) ? 3'h2 : 3'h4, 1'b0);
    if (n != 0) exp_q.push_back(3'h4);
    wait_q(200);
    stall = 1'b0;
    off(5);
    wrap_up();
  end
endmodule
